/* File: pwm_dbuf_pkg.sv */
// Purpose: shared constants and types for the pwm double buffer registers
// Assumes: 32-bit register port, word offsets as byte addresses
// Notes: counter size fixed at 18 value bits in six-bit fraction mode
`default_nettype none
package pwm_dbuf_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] CMP_BASE_OFS = 8'h44;
  localparam logic [7:0] CMP_STEP_OFS = 8'h04;
  localparam logic [7:0] PATT_BUF_OFS = 8'h64;
  localparam logic [7:0] WAVE_BUF_OFS = 8'h68;
  localparam logic [7:0] CTRL_OFS = 8'h70;
  localparam logic [7:0] ACTIVE_OFS = 8'h74;
  localparam logic [7:0] ACTIVE2_OFS = 8'h78;
  localparam int NUM_CH = 4;
  // ==========================================================
  // field positions
  localparam int CMP_VAL_LSB = 6;
  localparam int CMP_VAL_W = 18;
  localparam int CMP_FRAC_W = 6;
  localparam int CMP_USED_W = 24;
  localparam int PLEV_LSB = 8;
  localparam int PEN_LSB = 0;
  localparam int SWAP_LSB = 24;
  localparam int INV_LSB = 16;
  localparam int CCEN_LSB = 8;
  localparam int CPEN_BIT = 7;
  localparam int SLOPE_LSB = 4;
  localparam int WSEL_LSB = 0;
  localparam int CTRL_DBEN_BIT = 0;
  // ==========================================================
  // reset values
  localparam logic [31:0] CMP_RST = 32'h0000_0000;
  localparam logic [15:0] PATT_RST = 16'h0000;
  localparam logic [31:0] WAVE_RST = 32'h0000_0000;
  localparam logic [31:0] WAVE_MASK = 32'h0F0F_0FB7;
  localparam logic DBEN_RST = 1'b1;
  // ==========================================================
  // encodings
  typedef enum logic [1:0] {
    SINGLE_SLOPE_CYCLE = 2'h0,
    ALTERNATE_DUAL_SLOPE_CYCLE = 2'h1,
    DUAL_SLOPE_CYCLE = 2'h2,
    SLOPE_RESERVED = 2'h3
  } slope_mode_e;
  typedef enum logic [2:0] {
    WAVE_NORMAL_FREQ = 3'h0,
    WAVE_MATCH_FREQ = 3'h1,
    WAVE_NORMAL_PWM = 3'h2,
    WAVE_RESERVED = 3'h3,
    WAVE_DUAL_CRITICAL = 3'h4,
    WAVE_DUAL_BOTTOM = 3'h5,
    WAVE_DUAL_BOTH = 3'h6,
    WAVE_DUAL_TOP = 3'h7
  } wave_sel_e;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic [7:0] pattern_level;
    logic [7:0] pattern_drive_enable;
    logic [3:0] pair_exchange;
    logic [3:0] output_invert;
    logic [3:0] circular_channel_enable;
    logic circular_period_enable;
    logic [1:0] slope_mode;
    logic [2:0] waveform_select;
  } active_cfg_s;
  typedef struct packed {
    logic [NUM_CH-1:0][CMP_VAL_W-1:0] compare_value;
    logic [NUM_CH-1:0][CMP_FRAC_W-1:0] extra_cycle_count;
  } cmp_out_s;
  typedef struct packed {
    logic [NUM_CH-1:0][CMP_USED_W-1:0] cmp;
    logic [15:0] patt;
    logic [31:0] wave;
    logic dben;
    active_cfg_s act;
    logic [31:0] rdata;
  } state_s;
endpackage
`default_nettype wire

/* File: pwm_double_buffer_regs.sv */
// Purpose: double-buffered pwm configuration registers and unbuffered compare registers
// Assumes: update pulse comes from the counter core on clk_sys_in
// Notes: the dithering mode is fixed at six fraction bits
// How it works
// - compare register holds value in 23:6 and extra cycles in 5:0.
// - the 5:0 field says how many extra cycles widen the pulse.
// - reserved bits, including 31:24 of compare, always read zero.
// - compare value width equals the counter size.
// - pattern level buffer 15:8 is copied to active on update.
// - pattern drive enable buffer 7:0 is copied on update.
// - pair exchange buffer 27:24 is copied on update.
// - output invert buffer 19:16 is copied on update.
// - circular channel enable buffer 11:8 is copied on update.
// - circular period enable buffer bit 7 is copied on update.
// - slope mode buffer 5:4 is copied on update.
// - slope codes 0 single, 1 alternate dual, 2 dual, 3 reserved.
// - waveform select buffer 2:0 is copied on update.
// - waveform codes 0..2 and 4..7 as listed, 3 reserved.
`default_nettype none
module pwm_double_buffer_regs (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // counter core
  input wire logic update_in,
  output pwm_dbuf_pkg::active_cfg_s active_cfg_out,
  output pwm_dbuf_pkg::cmp_out_s cmp_out,
  output logic slope_reserved_out,
  output logic wave_reserved_out
);
  import pwm_dbuf_pkg::*;

  state_s st_r;
  state_s st_nxt;
  active_cfg_s buf_cfg;
  logic [31:0] rd_val;
  logic [7:0] ch_ofs [NUM_CH];

  // ==========================================================
  // buffered view, laid out like the active set
  always_comb begin
    buf_cfg.pattern_level = st_r.patt[PLEV_LSB +: 8];
    buf_cfg.pattern_drive_enable = st_r.patt[PEN_LSB +: 8];
    buf_cfg.pair_exchange = st_r.wave[SWAP_LSB +: 4];
    buf_cfg.output_invert = st_r.wave[INV_LSB +: 4];
    buf_cfg.circular_channel_enable = st_r.wave[CCEN_LSB +: 4];
    buf_cfg.circular_period_enable = st_r.wave[CPEN_BIT];
    buf_cfg.slope_mode = st_r.wave[SLOPE_LSB +: 2];
    buf_cfg.waveform_select = st_r.wave[WSEL_LSB +: 3];
  end

  // ==========================================================
  // per-channel compare offsets
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ofs
      assign ch_ofs[g] = CMP_BASE_OFS + 8'(g) * CMP_STEP_OFS;
    end
  endgenerate

  // ==========================================================
  // read mux; reserved bits come back as zero
  always_comb begin
    rd_val = 32'h0000_0000;
    for (int i = 0; i < NUM_CH; i++) begin
      if (reg_addr_in == ch_ofs[i]) begin
        rd_val = {8'h00, st_r.cmp[i]};
      end
    end
    if (reg_addr_in == PATT_BUF_OFS) begin
      rd_val = {16'h0000, st_r.patt};
    end else if (reg_addr_in == WAVE_BUF_OFS) begin
      rd_val = st_r.wave & WAVE_MASK;
    end else if (reg_addr_in == CTRL_OFS) begin
      rd_val = {31'h0000_0000, st_r.dben};
    end else if (reg_addr_in == ACTIVE_OFS) begin
      rd_val = {16'h0000, st_r.act.pattern_level,
                st_r.act.pattern_drive_enable};
    end else if (reg_addr_in == ACTIVE2_OFS) begin
      rd_val = {4'h0, st_r.act.pair_exchange, 4'h0,
                st_r.act.output_invert, 4'h0,
                st_r.act.circular_channel_enable,
                st_r.act.circular_period_enable, 1'b0,
                st_r.act.slope_mode, 1'b0, st_r.act.waveform_select};
    end
  end

  // ==========================================================
  // next state: writes, update transfer, read capture
  always_comb begin
    st_nxt = st_r;
    if (reg_wr_in) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (reg_addr_in == ch_ofs[i]) begin
          st_nxt.cmp[i] = reg_wdata_in[CMP_USED_W-1:0];
        end
      end
      if (reg_addr_in == PATT_BUF_OFS) begin
        st_nxt.patt = reg_wdata_in[15:0];
      end else if (reg_addr_in == WAVE_BUF_OFS) begin
        st_nxt.wave = reg_wdata_in & WAVE_MASK;
      end else if (reg_addr_in == CTRL_OFS) begin
        st_nxt.dben = reg_wdata_in[CTRL_DBEN_BIT];
      end
    end
    // one atomic copy on update; uses settled buffers so a
    // write in the update cycle waits for the next boundary
    if (update_in && st_r.dben) begin
      st_nxt.act = buf_cfg;
    end
    st_nxt.rdata = reg_rd_in ? rd_val : 32'h0000_0000;
    if (srst_in) begin
      st_nxt.cmp = '0;
      for (int i = 0; i < NUM_CH; i++) begin
        st_nxt.cmp[i] = CMP_RST[CMP_USED_W-1:0];
      end
      st_nxt.patt = PATT_RST;
      st_nxt.wave = WAVE_RST;
      st_nxt.dben = DBEN_RST;
      st_nxt.act = '0;
      st_nxt.rdata = 32'h0000_0000;
    end
  end

  // state register
  always_ff @(posedge clk_sys_in) begin
    st_r <= st_nxt;
  end

  // ==========================================================
  // outputs
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      cmp_out.compare_value[i] = st_r.cmp[i][CMP_VAL_LSB +: CMP_VAL_W];
      cmp_out.extra_cycle_count[i] = st_r.cmp[i][CMP_FRAC_W-1:0];
    end
  end
  assign active_cfg_out = st_r.act;
  assign reg_rdata_out = st_r.rdata;
  assign slope_reserved_out = (st_r.act.slope_mode == SLOPE_RESERVED);
  assign wave_reserved_out = (st_r.act.waveform_select == WAVE_RESERVED);
endmodule
`default_nettype wire

/* File: pwm_dbuf_properties.sv */
// Purpose: port checks of the pwm double buffer registers
// Assumes: one clock domain, bound to the top module
// Notes: the buffer enable is internal, copies are judged in the bench
`default_nettype none
module pwm_dbuf_properties (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  // counter core
  input wire logic update_in,
  input wire pwm_dbuf_pkg::active_cfg_s active_cfg_out,
  input wire logic slope_reserved_out,
  input wire logic wave_reserved_out
);
  import pwm_dbuf_pkg::*;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (srst_in);
  // ==========================================================
  // read side
  sequence s_rd(logic [7:0] a);
    reg_rd_in && reg_addr_in == a;
  endsequence
  property p_rd_idle;
    !$past(reg_rd_in) |-> reg_rdata_out == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");
  property p_cmp_rsv;
    s_rd(8'h44) or s_rd(8'h50) |=> reg_rdata_out[31:24] == 8'h00;
  endproperty
  a_cmp_rsv: assert property (p_cmp_rsv)
    else $error("compare top byte not zero");
  property p_patt_rsv;
    s_rd(8'h64) |=> reg_rdata_out[31:16] == 16'h0000;
  endproperty
  a_patt_rsv: assert property (p_patt_rsv)
    else $error("pattern upper half not zero");
  property p_wave_rsv;
    s_rd(8'h68) |=> (reg_rdata_out & 32'hF0F0_F048) == 32'h0000_0000;
  endproperty
  a_wave_rsv: assert property (p_wave_rsv)
    else $error("waveform reserved bits not zero");
  // active pattern read mirrors the live copy
  property p_act_rd;
    s_rd(8'h74) ##0 !update_in |=> reg_rdata_out ==
      {16'h0000, active_cfg_out.pattern_level,
      active_cfg_out.pattern_drive_enable};
  endproperty
  a_act_rd: assert property (p_act_rd)
    else $error("active pattern read differs");
  // ==========================================================
  // active set and flags
  property p_hold;
    !update_in |=> $stable(active_cfg_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("active set moved without update");
  property p_slope_flag;
    slope_reserved_out == (active_cfg_out.slope_mode == 2'h3);
  endproperty
  a_slope_flag: assert property (p_slope_flag)
    else $error("slope reserved flag wrong");
  property p_wave_flag;
    wave_reserved_out == (active_cfg_out.waveform_select == 3'h3);
  endproperty
  a_wave_flag: assert property (p_wave_flag)
    else $error("waveform reserved flag wrong");
endmodule
bind pwm_double_buffer_regs pwm_dbuf_properties chk_u (
  .clk_sys_in(clk_sys_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .update_in(update_in), .active_cfg_out(active_cfg_out),
  .slope_reserved_out(slope_reserved_out),
  .wave_reserved_out(wave_reserved_out));
`default_nettype wire

/* File: tb.sv */
// Purpose: register level bench of the pwm double buffer
// Assumes: update pulses ride beside writes, to the unmapped address 8'hFC or to the pattern buffer
// Notes: expected values are built from the bit layout only
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pwm_dbuf_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic upd = 1'b0;
  logic [31:0] rdata, w, m, prev;
  active_cfg_s act;
  cmp_out_s cmpo;
  logic slope_rsv, wave_rsv;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  pwm_double_buffer_regs dut_u (
    .clk_sys_in(clk_sys), .srst_in(srst), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .update_in(upd), .active_cfg_out(act),
    .cmp_out(cmpo), .slope_reserved_out(slope_rsv),
    .wave_reserved_out(wave_rsv));
  // 20 MHz clock
  initial forever #25 clk_sys = ~clk_sys;
  // ==========================================================
  // bus tasks; the update strobe rides beside a write
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d,
    input logic u);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    upd <= u;
    @(posedge clk_sys);
    wr <= 1'b0;
    upd <= 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", n, e, g);
      n_mismatch++;
    end
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(negedge clk_sys);
    chk($sformatf("reg %h", a), e, rdata);
  endtask
  // active waveform set packed in buffer layout
  function automatic logic [31:0] act_wave();
    return {4'h0, act.pair_exchange, 4'h0, act.output_invert, 4'h0,
      act.circular_channel_enable, act.circular_period_enable, 1'b0,
      act.slope_mode, 1'b0, act.waveform_select};
  endfunction
  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // hang guard, about 140 cycles are expected
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      stop_test();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    chk_rd(8'h70, 32'h0000_0001);
    chk_rd(8'h68, 32'h0000_0000);
    // compare regs with top value bit set, upper byte dropped
    for (int i = 0; i < 4; i++) begin
      w = 32'hFF80_0000 | (32'(i + 5) << 6) | 32'(i + 9);
      wr_reg(8'h44 + 8'(4 * i), w, 1'b0);
      chk_rd(8'h44 + 8'(4 * i), w & 32'h00FF_FFFF);
      chk("cmp", 32'h0002_0000 | 32'(i + 5), 32'(cmpo.compare_value[i]));
      chk("extra", 32'(i + 9), 32'(cmpo.extra_cycle_count[i]));
    end
    wr_reg(8'h5C, 32'hFFFF_FFFF, 1'b0);
    chk_rd(8'h5C, 32'h0000_0000);
    // pattern buffer stays hidden until an update
    wr_reg(8'h64, 32'hFFFF_A55A, 1'b0);
    chk_rd(8'h64, 32'h0000_A55A);
    chk_rd(8'h74, 32'h0000_0000);
    wr_reg(8'hFC, 32'h0000_0000, 1'b1);
    chk("level", 32'h0000_00A5, 32'(act.pattern_level));
    chk("enable", 32'h0000_005A, 32'(act.pattern_drive_enable));
    // every slope and waveform code, reserved bits written as ones
    for (int k = 0; k < 8; k++) begin
      w = {4'hF, 4'(k), 4'hF, 4'(~k), 4'hF, 4'(k + 3), 1'(k), 1'b1,
        2'(k), 1'b1, 3'(k)};
      m = w & 32'h0F0F_0FB7;
      prev = act_wave();
      wr_reg(8'h68, w, 1'b0);
      chk_rd(8'h68, m);
      chk("hold", prev, act_wave());
      wr_reg(8'hFC, 32'h0000_0000, 1'b1);
      chk("active", m, act_wave());
      chk("slope", 32'(k % 4), 32'(act.slope_mode));
      chk_rd(8'h78, m);
      chk("rsv", 32'(k % 4 == 3) + 32'(k == 3) * 2,
        32'(slope_rsv) + 32'(wave_rsv) * 2);
    end
    // buffering off ignores updates; a write beside an update loses
    wr_reg(8'h70, 32'h0000_0000, 1'b0);
    wr_reg(8'h64, 32'h0000_1234, 1'b1);
    wr_reg(8'hFC, 32'h0000_0000, 1'b1);
    chk_rd(8'h74, 32'h0000_A55A);
    wr_reg(8'h70, 32'h0000_0001, 1'b0);
    wr_reg(8'h64, 32'h0000_5678, 1'b1);
    chk_rd(8'h74, 32'h0000_1234);
    wr_reg(8'hFC, 32'h0000_0000, 1'b1);
    chk_rd(8'h74, 32'h0000_5678);
    // second reset in mid-run, driven right after a rising edge
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    chk_rd(8'h74, 32'h0000_0000);
    chk_rd(8'h78, 32'h0000_0000);
    chk_rd(8'h68, 32'h0000_0000);
    chk_rd(8'h70, 32'h0000_0001);
    stop_test();
  end
endmodule
`default_nettype wire
